// [hdl/rtc_ctrl.sv]
// Functional notes
// - control register read/write, clears on reset
// - control bit 7 reads zero always
// - clock enable routes 16 kHz clock to pin (here ANDed with port flip-flop; low holds pin low)
// - port flip-flop and pin stay accessible
// - run low stops oscillator, resets divider
// - run high lets divider count
// - period select: one second or minute
// - flag set at each completed period
// - software sets/clears flag; hardware never clears
// - enable bit gates flag onto request
// - trim register eight bits, clears on reset
// - minute lengthened by trim sixteenth-kHz steps
// - trim clocks counted once after minute
// - flag set on period clock falling edge
// - request ORed into external interrupt
//
// Decided for this implementation: strobed register access.
`include "rtc_map.svh"

module rtc_ctrl #(
    parameter int TICKS_PER_SEC = `RTC_TICKS_PER_SEC,
    parameter int SECS_PER_MIN  = `RTC_SECS_PER_MIN
) (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic [7:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    output logic      [7:0] bus_rdata,
    input  wire logic       osc_32k_in,
    output logic            osc_enable,
    input  wire logic       port_wr,
    input  wire logic       port_wdata,
    output logic            port_ff,
    output logic            pin_level,
    input  wire logic       pin_in,
    output logic            pin_out,
    output logic            pin_oe_n,
    input  wire logic       ext_irq_in,
    output logic            ext_irq_out,
    output logic            irq
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    // exact match of one register offset
    function automatic logic reg_hit(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        return addr == ofs;
    endfunction

    // event word widened to the bus
    function automatic rtc_pkg::byte_t evt_word(
        input logic [`EVT_WIDTH-1:0] evt
    );
        return {{(8-`EVT_WIDTH){1'b0}}, evt};
    endfunction

    logic wr_control;
    logic wr_trim;
    logic wr_clear;
    logic wr_enable;

    always_comb begin
        wr_control = bus_wr && reg_hit(bus_addr, `RTC_CONTROL_OFS);
        wr_trim    = bus_wr && reg_hit(bus_addr, `RTC_TRIM_OFS);
        wr_clear   = bus_wr && reg_hit(bus_addr, `RTC_EVT_CLEAR_OFS);
        wr_enable  = bus_wr && reg_hit(bus_addr, `RTC_EVT_ENABLE_OFS);
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator input crossing

    logic osc_level;
    logic osc_prev_q;
    logic osc_prev_d;
    logic osc_edge;

    pin_sync u_osc_sync (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .async_in (osc_32k_in),
        .level    (osc_level)
    );

    always_comb begin
        osc_prev_d = osc_level;
        osc_edge   = osc_level && !osc_prev_q;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and trim registers

    rtc_pkg::byte_t control_q;
    rtc_pkg::byte_t control_d;
    rtc_pkg::byte_t trim_q;
    rtc_pkg::byte_t trim_d;
    logic           run;
    logic           period_select;
    logic           clk16k_out_enable;
    logic           tick_irq_enable;
    logic           tick_flag;
    logic           period_done;
    logic           clk16k;
    logic           sec_done;
    logic           min_done;

    always_comb begin
        run               = control_q[`CTL_RUN_BIT];
        period_select     = control_q[`CTL_PERIOD_SEL_BIT];
        clk16k_out_enable = control_q[`CTL_CLKOUT_EN_BIT];
        tick_irq_enable   = control_q[`CTL_TICK_IRQ_EN_BIT];
        tick_flag         = control_q[`CTL_TICK_FLAG_BIT];
        // one second when set, one minute when clear
        period_done       = period_select ? sec_done : min_done;
    end

    always_comb begin
        control_d = control_q;
        trim_d    = trim_q;
        if (wr_control) begin
            // bit 7 never stores; test bits are kept as written
            control_d = bus_wdata & `CTL_WRITE_MASK;
        end
        if (period_done) begin
            // hardware set wins over a same-cycle clear
            control_d[`CTL_TICK_FLAG_BIT] = 1'b1;
        end
        if (wr_trim) begin
            trim_d = bus_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            control_q <= `RTC_CONTROL_RST;
            trim_q    <= `RTC_TRIM_RST;
        end else begin
            control_q <= control_d;
            trim_q    <= trim_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // divider chain

    rtc_divider #(
        .TICKS_PER_SEC (TICKS_PER_SEC),
        .SECS_PER_MIN  (SECS_PER_MIN)
    ) u_divider (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .run      (run),
        .osc_edge (osc_edge),
        .trim     (trim_q),
        .clk16k   (clk16k),
        .sec_done (sec_done),
        .min_done (min_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // event status, enable, interrupt

    logic [`EVT_WIDTH-1:0] evt_status_q;
    logic [`EVT_WIDTH-1:0] evt_status_d;
    logic [`EVT_WIDTH-1:0] evt_enable_q;
    logic [`EVT_WIDTH-1:0] evt_enable_d;
    logic [`EVT_WIDTH-1:0] evt_set;
    logic                  irq_q;
    logic                  irq_d;
    logic                  ext_irq_q;
    logic                  ext_irq_d;

    always_comb begin
        evt_set                  = '0;
        evt_set[`EVT_SECOND_BIT] = sec_done;
        evt_set[`EVT_MINUTE_BIT] = min_done;
        evt_set[`EVT_TICK_BIT]   = period_done;
        evt_status_d = evt_status_q;
        if (wr_clear) begin
            evt_status_d = evt_status_q & ~bus_wdata[`EVT_WIDTH-1:0];
        end
        // set wins over clear
        evt_status_d = evt_status_d | evt_set;
        evt_enable_d = evt_enable_q;
        if (wr_enable) begin
            evt_enable_d = bus_wdata[`EVT_WIDTH-1:0];
        end
        irq_d     = |(evt_status_d & evt_enable_d);
        // enabled flag joins the external interrupt request
        ext_irq_d = ext_irq_in
                  | (control_d[`CTL_TICK_FLAG_BIT]
                  &  control_d[`CTL_TICK_IRQ_EN_BIT]);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            evt_status_q <= `RTC_EVT_RST;
            evt_enable_q <= `RTC_EVT_RST;
            irq_q        <= 1'b0;
            ext_irq_q    <= 1'b0;
        end else begin
            evt_status_q <= evt_status_d;
            evt_enable_q <= evt_enable_d;
            irq_q        <= irq_d;
            ext_irq_q    <= ext_irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared pin: port flip-flop and 16 kHz output

    logic pin_sampled;
    logic port_ff_q;
    logic port_ff_d;
    logic pin_out_q;
    logic pin_out_d;
    logic pin_oe_n_q;
    logic pin_oe_n_d;
    logic osc_enable_q;

    pin_sync u_pin_sync (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .async_in (pin_in),
        .level    (pin_sampled)
    );

    always_comb begin
        port_ff_d = port_ff_q;
        if (port_wr) begin
            // port writes still reach the flip-flop with the clock out
            port_ff_d = port_wdata;
        end
        if (clk16k_out_enable) begin
            // flip-flop held high by software avoids a fight
            pin_out_d  = clk16k & port_ff_d;
            pin_oe_n_d = 1'b0;
        end else begin
            // quasi-bidirectional port line: drive low only
            pin_out_d  = 1'b0;
            pin_oe_n_d = port_ff_d;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            port_ff_q    <= 1'b1;
            pin_out_q    <= 1'b0;
            pin_oe_n_q   <= 1'b1;
            osc_enable_q <= 1'b0;
        end else begin
            port_ff_q    <= port_ff_d;
            pin_out_q    <= pin_out_d;
            pin_oe_n_q   <= pin_oe_n_d;
            osc_enable_q <= control_d[`CTL_RUN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port

    rtc_pkg::byte_t rdata_q;
    rtc_pkg::byte_t rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (bus_rd) begin
            unique case (bus_addr)
                `RTC_CONTROL_OFS:    rdata_d = control_q & `CTL_WRITE_MASK;
                `RTC_TRIM_OFS:       rdata_d = trim_q;
                `RTC_EVT_STATUS_OFS: rdata_d = evt_word(evt_status_q);
                `RTC_EVT_ENABLE_OFS: rdata_d = evt_word(evt_enable_q);
                default:             rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign bus_rdata   = rdata_q;
    assign osc_enable  = osc_enable_q;
    assign port_ff     = port_ff_q;
    assign pin_level   = pin_sampled;
    assign pin_out     = pin_out_q;
    assign pin_oe_n    = pin_oe_n_q;
    assign ext_irq_out = ext_irq_q;
    assign irq         = irq_q;

endmodule

// [shared/rtc_map.svh]
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// register offsets
`define RTC_CONTROL_OFS      8'h20
`define RTC_TRIM_OFS         8'h21
`define RTC_EVT_STATUS_OFS   8'h22
`define RTC_EVT_CLEAR_OFS    8'h23
`define RTC_EVT_ENABLE_OFS   8'h24

// rtc_control field positions
`define CTL_TICK_IRQ_EN_BIT  0
`define CTL_TICK_FLAG_BIT    1
`define CTL_PERIOD_SEL_BIT   2
`define CTL_RUN_BIT          3
`define CTL_CLKOUT_EN_BIT    4
`define CTL_TEST_A_BIT       5
`define CTL_TEST_B_BIT       6
`define CTL_WRITE_MASK       8'h7f

// event status field positions
`define EVT_SECOND_BIT       0
`define EVT_MINUTE_BIT       1
`define EVT_TICK_BIT         2
`define EVT_WIDTH            3

// reset values
`define RTC_CONTROL_RST      8'h00
`define RTC_TRIM_RST         8'h00
`define RTC_EVT_RST          3'h0

// divider counts, in 16 kHz clocks and seconds
`define RTC_TICKS_PER_SEC    16384
`define RTC_SECS_PER_MIN     60

`endif

// [shared/rtc_pkg.sv]
package rtc_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic {
        PH_COUNT   = 1'b0,
        PH_STRETCH = 1'b1
    } trim_phase_t;

endpackage

// [hdl/pin_sync.sv]
module pin_sync (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic async_in,
    output logic      level
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic level_d;

    // a change counts once the second and third stage agree
    always_comb begin
        level_d = level_q;
        if (s2_q == s3_q) begin
            level_d = s3_q;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q    <= async_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end

    assign level = level_q;

endmodule

// [hdl/rtc_divider.sv]
`include "rtc_map.svh"

module rtc_divider #(
    parameter int TICKS_PER_SEC = `RTC_TICKS_PER_SEC,
    parameter int SECS_PER_MIN  = `RTC_SECS_PER_MIN
) (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       run,
    input  wire logic       osc_edge,
    input  wire logic [7:0] trim,
    output logic            clk16k,
    output logic            sec_done,
    output logic            min_done
);

    localparam int TW = $clog2(TICKS_PER_SEC);
    localparam int SW = $clog2(SECS_PER_MIN);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICKS_PER_SEC - 1);
    localparam logic [SW-1:0] SEC_LAST  = SW'(SECS_PER_MIN - 1);

    logic                 half_q,    half_d;
    logic [TW-1:0]        tick_q,    tick_d;
    logic [SW-1:0]        sec_q,     sec_d;
    logic [7:0]           stretch_q, stretch_d;
    rtc_pkg::trim_phase_t phase_q,   phase_d;

    always_comb begin
        half_d    = half_q;
        tick_d    = tick_q;
        sec_d     = sec_q;
        stretch_d = stretch_q;
        phase_d   = phase_q;
        sec_done  = 1'b0;
        min_done  = 1'b0;
        if (!run) begin
            // chain held in reset while stopped
            half_d    = 1'b0;
            tick_d    = '0;
            sec_d     = '0;
            stretch_d = 8'h00;
            phase_d   = rtc_pkg::PH_COUNT;
        end else if (osc_edge) begin
            half_d = ~half_q;
            if (half_q) begin
                unique case (phase_q)
                    rtc_pkg::PH_STRETCH: begin
                        // extra 16 kHz clocks lengthen the first second
                        stretch_d = stretch_q - 8'h01;
                        if (stretch_q == 8'h01) begin
                            phase_d = rtc_pkg::PH_COUNT;
                        end
                    end
                    rtc_pkg::PH_COUNT: begin
                        if (tick_q == TICK_LAST) begin
                            tick_d   = '0;
                            sec_done = 1'b1;
                            if (sec_q == SEC_LAST) begin
                                sec_d    = '0;
                                min_done = 1'b1;
                                if (trim != 8'h00) begin
                                    phase_d   = rtc_pkg::PH_STRETCH;
                                    stretch_d = trim;
                                end
                            end else begin
                                sec_d = sec_q + SW'(1);
                            end
                        end else begin
                            tick_d = tick_q + TW'(1);
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            half_q    <= 1'b0;
            tick_q    <= '0;
            sec_q     <= '0;
            stretch_q <= 8'h00;
            phase_q   <= rtc_pkg::PH_COUNT;
        end else begin
            half_q    <= half_d;
            tick_q    <= tick_d;
            sec_q     <= sec_d;
            stretch_q <= stretch_d;
            phase_q   <= phase_d;
        end
    end

    assign clk16k = half_q;

endmodule

// [test/rtc_ctrl_properties.sv]
module rtc_ctrl_properties (
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic       osc_enable,
    input wire logic       port_wr,
    input wire logic       port_wdata,
    input wire logic       port_ff,
    input wire logic       pin_oe_n,
    input wire logic       ext_irq_in,
    input wire logic       ext_irq_out,
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_ctl_wr;
        bus_wr && bus_addr == 8'h20;
    endsequence
    sequence s_quiet;
        !bus_wr;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 8'h00)
        else $error("read data not idle");
    a_bit7_zero: assert property (bus_rd && bus_addr == 8'h20 |=> !bus_rdata[7])
        else $error("control bit 7 not zero");
    a_run_starts: assert property (s_ctl_wr ##0 bus_wdata[3] ##1 s_quiet |=> osc_enable)
        else $error("oscillator not enabled");
    a_stop_halts: assert property (s_ctl_wr ##0 !bus_wdata[3] ##1 s_quiet |=> !osc_enable)
        else $error("oscillator not stopped");
    a_trim_back: assert property (bus_wr && bus_addr == 8'h21 ##1 bus_rd && bus_addr == 8'h21
        |=> bus_rdata == $past(bus_wdata, 2))
        else $error("trim readback wrong");
    a_ext_or: assert property (ext_irq_in |=> ext_irq_out)
        else $error("external request lost");
    a_port_write: assert property (port_wr |=> port_ff == $past(port_wdata))
        else $error("port flip-flop not written");
    a_clkout_drive: assert property (s_ctl_wr ##0 bus_wdata[4] ##1 s_quiet |=> !pin_oe_n)
        else $error("clock output not driven");
    a_flag_gated: assert property (s_ctl_wr ##0 bus_wdata[1:0] == 2'b10 && !ext_irq_in
        ##1 (s_quiet and !ext_irq_in) |=> !ext_irq_out)
        else $error("disabled flag requests");
    a_flag_raises: assert property (s_ctl_wr ##0 bus_wdata[1:0] == 2'b11 ##1 s_quiet
        |=> ext_irq_out)
        else $error("software flag no request");
    a_irq_masked: assert property (bus_wr && bus_addr == 8'h24 && bus_wdata == 8'h00
        ##1 s_quiet |=> !irq)
        else $error("masked irq high");
endmodule

bind rtc_ctrl rtc_ctrl_properties chk_i (
    .sys_clk(sys_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .osc_enable(osc_enable),
    .port_wr(port_wr), .port_wdata(port_wdata), .port_ff(port_ff), .pin_oe_n(pin_oe_n),
    .ext_irq_in(ext_irq_in), .ext_irq_out(ext_irq_out), .irq(irq)
);

// [test/rtc_ctrl_bench.sv]
module rtc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       sys_clk, nrst, bus_wr, bus_rd, osc_32k_in, port_wr, port_wdata, ext_irq_in;
    logic [7:0] bus_addr, bus_wdata, bus_rdata;
    logic       osc_enable, port_ff, pin_level, pin_out, pin_oe_n, ext_irq_out, irq;
    wire logic  pin_in;
    int         n_fail, checks_done, cycles;

    // pull-up when nobody drives the pin
    assign pin_in = pin_oe_n ? 1'b1 : pin_out;

    rtc_ctrl #(.TICKS_PER_SEC(4), .SECS_PER_MIN(3)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .osc_32k_in(osc_32k_in),
        .osc_enable(osc_enable), .port_wr(port_wr), .port_wdata(port_wdata),
        .port_ff(port_ff), .pin_level(pin_level), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .ext_irq_in(ext_irq_in), .ext_irq_out(ext_irq_out), .irq(irq)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 chk("rdata", e, bus_rdata);
    endtask
    // write then read back with no gap
    task wrd(input logic [7:0] a, input logic [7:0] d);
        wr(a, d);
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 chk("readback", d, bus_rdata);
    endtask
    task osc(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            osc_32k_in <= 1'b1;
            repeat (5) @(posedge sys_clk);
            osc_32k_in <= 1'b0;
            repeat (5) @(posedge sys_clk);
        end
    endtask
    task port(input logic v);
        @(posedge sys_clk);
        port_wr    <= 1'b1;
        port_wdata <= v;
        @(posedge sys_clk);
        port_wr <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            n_fail++;
            conclude;
        end
    end
    initial begin
        {nrst, bus_wr, bus_rd, osc_32k_in, port_wr, port_wdata, ext_irq_in} = '0;
        bus_addr  = 8'h00;
        bus_wdata = 8'h00;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        #1 chk("osc_enable", 8'h00, {7'h00, osc_enable});
        chk("port_ff", 8'h01, {7'h00, port_ff});
        rd(8'h20, 8'h00);
        rd(8'h21, 8'h00);
        rd(8'h22, 8'h00);
        $display("test reset done");
        wr(8'h20, 8'h93);
        rd(8'h20, 8'h13);
        chk("ext_irq_out", 8'h01, {7'h00, ext_irq_out});
        wrd(8'h21, 8'h3c);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        rd(8'h23, 8'h00);
        wr(8'h20, 8'h00);
        rd(8'h20, 8'h00);
        chk("ext_irq_out", 8'h00, {7'h00, ext_irq_out});
        wr(8'h20, 8'h02);
        rd(8'h20, 8'h02);
        chk("ext_irq_out", 8'h00, {7'h00, ext_irq_out});
        @(posedge sys_clk);
        ext_irq_in <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk("ext_irq_out", 8'h01, {7'h00, ext_irq_out});
        @(posedge sys_clk);
        ext_irq_in <= 1'b0;
        $display("test registers done");
        wr(8'h20, 8'h0c);
        rd(8'h20, 8'h0c);
        chk("osc_enable", 8'h01, {7'h00, osc_enable});
        osc(7);
        rd(8'h20, 8'h0c);
        osc(1);
        rd(8'h20, 8'h0e);
        rd(8'h22, 8'h05);
        wrd(8'h24, 8'h07);
        chk("irq", 8'h01, {7'h00, irq});
        wr(8'h24, 8'h00);
        rd(8'h24, 8'h00);
        chk("irq", 8'h00, {7'h00, irq});
        wr(8'h23, 8'h07);
        rd(8'h22, 8'h00);
        $display("test second done");
        wr(8'h20, 8'h00);
        osc(10);
        rd(8'h20, 8'h00);
        wr(8'h21, 8'h02);
        wr(8'h20, 8'h08);
        osc(23);
        rd(8'h20, 8'h08);
        osc(1);
        rd(8'h20, 8'h0a);
        wr(8'h20, 8'h08);
        osc(27);
        rd(8'h20, 8'h08);
        osc(1);
        rd(8'h20, 8'h0a);
        $display("test minute done");
        wr(8'h20, 8'h00);
        port(1'b0);
        chk("pin_oe_n", 8'h00, {7'h00, pin_oe_n});
        chk("pin_level", 8'h00, {7'h00, pin_level});
        port(1'b1);
        chk("pin_level", 8'h01, {7'h00, pin_level});
        wr(8'h20, 8'h10);
        rd(8'h20, 8'h10);
        chk("pin_oe_n", 8'h00, {7'h00, pin_oe_n});
        wr(8'h20, 8'h18);
        osc(1);
        #1 chk("pin_out", 8'h01, {7'h00, pin_out});
        port(1'b1);
        chk("port_ff", 8'h01, {7'h00, port_ff});
        chk("pin_level", 8'h01, {7'h00, pin_level});
        osc(1);
        #1 chk("pin_out", 8'h00, {7'h00, pin_out});
        $display("test pin done");
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(8'h20, 8'h00);
        rd(8'h21, 8'h00);
        chk("osc_enable", 8'h00, {7'h00, osc_enable});
        chk("pin_oe_n", 8'h01, {7'h00, pin_oe_n});
        $display("test reset again done");
        conclude;
    end
endmodule
